// file: logic/uart_shadow_map.vh
// Purpose: Register offsets, fields and constants of the shadow data port
// Assumes: Word addressed by byte address, 32-bit data
// Notes:   Window base is alias 0; aliases 9 and 10 fall at their offsets
`ifndef UART_SHADOW_MAP_VH
`define UART_SHADOW_MAP_VH
`define WIN_BASE          32'h50001130
`define ALIAS9_OFS        32'h50001154
`define ALIAS10_OFS       32'h50001158
`define WIN_LAST          32'h5000116c
`define LINE_STAT_OFS     32'h50001014
`define FIFO_CTRL_OFS     32'h50001008
`define CTRL_OFS          32'h50001010
`define IRQ_STAT_OFS      32'h50001030
`define IRQ_MASK_OFS      32'h50001034
`define STAT_READY_BIT    0
`define STAT_OVERRUN_BIT  1
`define STAT_TX_EMPTY_BIT 5
`define FIFO_EN_BIT       0
`define CTRL_IR_BIT       0
`define IRQ_RX_BIT        0
`define IRQ_OE_BIT        1
`define IRQ_TX_EMPTY_BIT  2
`define FIFO_DEPTH        16
`define FIFO_AW           4
`define BAUD_DIV          16'h0364
`endif

// file: logic/shadow_fifo.v
// Purpose: 16 x 8 FIFO with registered read data
// Assumes: Push on full and pop on empty are ignored
// Notes:   Head data valid one cycle after any change
`timescale 1ns/1ns
`default_nettype none
`include "uart_shadow_map.vh"
module shadow_fifo (
   input  wire       sys_clk,
   input  wire       nrst,
   input  wire       flush,
   input  wire       push,
   input  wire [7:0] push_data,
   input  wire       pop,
   output reg  [7:0] head_data,
   output wire       full,
   output wire       empty
);
   reg [7:0]           mem [0:`FIFO_DEPTH-1];
   reg [`FIFO_AW-1:0]  wr_ptr_r;
   reg [`FIFO_AW-1:0]  rd_ptr_r;
   reg [`FIFO_AW:0]    count_r;
   wire                do_push;
   wire                do_pop;
   wire [`FIFO_AW-1:0] rd_next;
   assign full    = (count_r == `FIFO_DEPTH);
   assign empty   = (count_r == 0);
   assign do_push = push && !full;
   assign do_pop  = pop && !empty;
   assign rd_next = do_pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
   always @(posedge sys_clk) begin
      if (do_push) begin
         mem[wr_ptr_r] <= push_data;
      end
   end
   always @(posedge sys_clk) begin
      if (!nrst || flush) begin
         wr_ptr_r  <= {`FIFO_AW{1'b0}};
         rd_ptr_r  <= {`FIFO_AW{1'b0}};
         count_r   <= {(`FIFO_AW+1){1'b0}};
         head_data <= 8'h00;
      end else begin
         if (do_push) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         rd_ptr_r <= rd_next;
         count_r  <= count_r + {{`FIFO_AW{1'b0}}, do_push} - {{`FIFO_AW{1'b0}}, do_pop};
         if (do_push && (empty || (do_pop && count_r == 1))) begin
            head_data <= push_data;
         end else begin
            head_data <= mem[rd_next];
         end
      end
   end
endmodule
`default_nettype wire

// file: logic/serial_phy.v
// Purpose: 8N1 serial transmitter and receiver
// Assumes: Line input synchronous to sys_clk
// Notes:   Idle line is high; bit time is BAUD_DIV cycles
`timescale 1ns/1ns
`default_nettype none
`include "uart_shadow_map.vh"
module serial_phy (
   input  wire       sys_clk,
   input  wire       nrst,
   input  wire       tx_start,
   input  wire [7:0] tx_byte,
   output wire       tx_busy,
   output reg        tx_line,
   input  wire       rx_line,
   output reg        rx_done,
   output reg  [7:0] rx_byte
);
   reg [15:0] tx_cnt_r;
   reg [3:0]  tx_bit_r;
   reg [8:0]  tx_sh_r;
   reg        tx_act_r;
   reg [15:0] rx_cnt_r;
   reg [3:0]  rx_bit_r;
   reg        rx_act_r;
   reg [7:0]  rx_sh_r;
   assign tx_busy = tx_act_r;
   always @(posedge sys_clk) begin
      if (!nrst) begin
         tx_cnt_r <= 16'h0000;
         tx_bit_r <= 4'h0;
         tx_sh_r  <= 9'h1ff;
         tx_act_r <= 1'b0;
         tx_line  <= 1'b1;
      end else if (!tx_act_r) begin
         tx_line <= 1'b1;
         if (tx_start) begin
            tx_act_r <= 1'b1;
            tx_sh_r  <= {1'b1, tx_byte};
            tx_line  <= 1'b0;
            tx_cnt_r <= 16'h0000;
            tx_bit_r <= 4'h0;
         end
      end else if (tx_cnt_r == `BAUD_DIV - 1) begin
         tx_cnt_r <= 16'h0000;
         if (tx_bit_r == 4'h9) begin
            tx_act_r <= 1'b0;
            tx_line  <= 1'b1;
         end else begin
            tx_line  <= tx_sh_r[0];
            tx_sh_r  <= {1'b1, tx_sh_r[8:1]};
            tx_bit_r <= tx_bit_r + 4'h1;
         end
      end else begin
         tx_cnt_r <= tx_cnt_r + 16'h0001;
      end
   end
   always @(posedge sys_clk) begin
      if (!nrst) begin
         rx_cnt_r <= 16'h0000;
         rx_bit_r <= 4'h0;
         rx_act_r <= 1'b0;
         rx_sh_r  <= 8'h00;
         rx_done  <= 1'b0;
         rx_byte  <= 8'h00;
      end else begin
         rx_done <= 1'b0;
         if (!rx_act_r) begin
            if (!rx_line) begin
               rx_act_r <= 1'b1;
               rx_cnt_r <= `BAUD_DIV >> 1;
               rx_bit_r <= 4'h0;
            end
         end else if (rx_cnt_r == `BAUD_DIV - 1) begin
            rx_cnt_r <= 16'h0000;
            rx_bit_r <= rx_bit_r + 4'h1;
            if (rx_bit_r == 4'h0 && rx_line) begin
               rx_act_r <= 1'b0;
            end else if (rx_bit_r == 4'h9) begin
               rx_act_r <= 1'b0;
               rx_done  <= 1'b1;
               rx_byte  <= rx_sh_r;
            end else if (rx_bit_r != 4'h0) begin
               rx_sh_r <= {rx_line, rx_sh_r[7:1]};
            end
         end else begin
            rx_cnt_r <= rx_cnt_r + 16'h0001;
         end
      end
   end
endmodule
`default_nettype wire

// file: logic/uart_shadow_data_port.v
// Operation
// R1 - Read returns last received character, low byte
// R2 - Data valid only while data ready set
// R3 - FIFO off: new character overwrites, flags overrun
// R4 - FIFO on: read returns receive FIFO head
// R5 - Full receive FIFO: drop new, flag overrun
// R6 - Written character queued to serial or infrared
// R7 - Software writes only while holding empty set
// R8 - FIFO off: one write clears holding empty
// R9 - FIFO off: extra write replaces held character
// R10 - FIFO on: up to 16 writes before full
// R11 - Write to full transmit FIFO is discarded
// R12 - Sixteen word aliases share one data path
// R13 - Upper byte reads zero, writes ignored
//
// Purpose: Mirrored receive/transmit data window of a UART
// Assumes: Plain register port, read data one cycle after strobe
// Notes:   Infrared output is active low; line status is read only
`timescale 1ns/1ns
`default_nettype none
`include "uart_shadow_map.vh"
module uart_shadow_data_port (
   input  wire        sys_clk,
   input  wire        nrst,
   input  wire [31:0] addr,
   input  wire [31:0] wdata,
   input  wire        wr,
   input  wire        rd,
   output reg  [31:0] rdata,
   input  wire        serial_in,
   output wire        serial_out,
   input  wire        ir_in,
   output wire        ir_out_n,
   output wire        irq
);
   reg        fifo_en_r;
   reg        ir_mode_r;
   reg        ready_r;
   reg        oe_r;
   reg        tx_empty_r;
   reg  [7:0] rx_hold_r;
   reg  [7:0] tx_hold_r;
   reg        tx_hold_full_r;
   reg  [2:0] irq_stat_r;
   reg  [2:0] irq_mask_r;
   reg  [2:0] irq_stat_nxt;
   reg  [31:0] rdata_nxt;
   wire       win_hit;
   wire       rx_done;
   wire [7:0] rx_byte;
   wire       tx_busy;
   wire       tx_line;
   wire       rx_line;
   wire       data_rd;
   wire       data_wr;
   wire       rxf_full;
   wire       rxf_empty;
   wire [7:0] rxf_head;
   wire       txf_full;
   wire       txf_empty;
   wire [7:0] txf_head;
   wire       tx_start;
   wire       fifo_wr;
   wire       overrun_ev;
   wire       tx_empty_ev;
   reg        tx_busy_d_r;

   function in_window;
      input [31:0] a;
      begin
         in_window = (a >= `WIN_BASE) && (a <= `WIN_LAST) && (a[1:0] == 2'b00);
      end
   endfunction

   assign win_hit = in_window(addr);                                    // R12
   assign data_rd = rd && win_hit;
   assign data_wr = wr && win_hit;
   assign rx_line = ir_mode_r ? ir_in : serial_in;                     // R1
   assign serial_out = ir_mode_r ? 1'b1 : tx_line;                      // R6
   assign ir_out_n   = ir_mode_r ? tx_line : 1'b1;                      // R6
   assign fifo_wr    = fifo_en_r && data_wr;                            // R10
   assign overrun_ev = rx_done && (fifo_en_r ? rxf_full : ready_r);     // R3 R5
   assign tx_start   = !tx_busy && !tx_busy_d_r &&
                       (fifo_en_r ? !txf_empty : tx_hold_full_r);
   assign tx_empty_ev = !tx_empty_r &&
                       (fifo_en_r ? (txf_empty && !fifo_wr) : (!tx_hold_full_r && !data_wr));

   shadow_fifo rx_fifo (
      .sys_clk   (sys_clk),
      .nrst      (nrst),
      .flush     (!fifo_en_r),
      .push      (rx_done && fifo_en_r),                                // R5
      .push_data (rx_byte),
      .pop       (data_rd && fifo_en_r),                                // R4
      .head_data (rxf_head),
      .full      (rxf_full),
      .empty     (rxf_empty)
   );

   shadow_fifo tx_fifo (
      .sys_clk   (sys_clk),
      .nrst      (nrst),
      .flush     (!fifo_en_r),
      .push      (fifo_wr),                                             // R11
      .push_data (wdata[7:0]),
      .pop       (tx_start && fifo_en_r),
      .head_data (txf_head),
      .full      (txf_full),
      .empty     (txf_empty)
   );

   serial_phy phy (
      .sys_clk  (sys_clk),
      .nrst     (nrst),
      .tx_start (tx_start),
      .tx_byte  (fifo_en_r ? txf_head : tx_hold_r),
      .tx_busy  (tx_busy),
      .tx_line  (tx_line),
      .rx_line  (rx_line),
      .rx_done  (rx_done),
      .rx_byte  (rx_byte)
   );

   always @(posedge sys_clk) begin
      if (!nrst) begin
         fifo_en_r   <= 1'b0;
         ir_mode_r   <= 1'b0;
         ready_r     <= 1'b0;
         oe_r        <= 1'b0;
         tx_empty_r  <= 1'b1;
         rx_hold_r   <= 8'h00;
         tx_hold_r   <= 8'h00;
         tx_hold_full_r <= 1'b0;
         irq_mask_r  <= 3'h0;
         irq_stat_r  <= 3'h0;
         tx_busy_d_r <= 1'b0;
      end else begin
         tx_busy_d_r <= tx_start;
         irq_stat_r  <= irq_stat_nxt;
         if (wr && addr == `FIFO_CTRL_OFS) begin
            fifo_en_r <= wdata[`FIFO_EN_BIT];
         end
         if (wr && addr == `CTRL_OFS) begin
            ir_mode_r <= wdata[`CTRL_IR_BIT];
         end
         if (wr && addr == `IRQ_MASK_OFS) begin
            irq_mask_r <= wdata[2:0];
         end
         // Receive holding register in non-FIFO mode
         if (rx_done && !fifo_en_r) begin
            rx_hold_r <= rx_byte;                                       // R3
         end
         // Data ready follows holding register or FIFO level
         if (fifo_en_r) begin
            ready_r <= !rxf_empty || (rx_done && !rxf_full);            // R2
         end else if (rx_done) begin
            ready_r <= 1'b1;                                            // R2
         end else if (data_rd) begin
            ready_r <= 1'b0;
         end
         // Overrun sets over a status read clearing it
         if (overrun_ev) begin
            oe_r <= 1'b1;                                               // R3 R5
         end else if (rd && addr == `LINE_STAT_OFS) begin
            oe_r <= 1'b0;
         end
         // Transmit holding register in non-FIFO mode
         if (data_wr && !fifo_en_r) begin
            tx_hold_r      <= wdata[7:0];                               // R9 R13
            tx_hold_full_r <= 1'b1;
         end else if (tx_start && !fifo_en_r) begin
            tx_hold_full_r <= 1'b0;
         end
         if (fifo_en_r ? (fifo_wr || !txf_empty) : data_wr) begin
            tx_empty_r <= 1'b0;                                         // R8 R10
         end else if (tx_empty_ev) begin
            tx_empty_r <= 1'b1;
         end
      end
   end

   // Sticky interrupt status, set wins over write-one clear
   always @* begin
      irq_stat_nxt = irq_stat_r;
      if (wr && addr == `IRQ_STAT_OFS) begin
         irq_stat_nxt = irq_stat_r & ~wdata[2:0];
      end
      if (rx_done) begin
         irq_stat_nxt[`IRQ_RX_BIT] = 1'b1;
      end
      if (overrun_ev) begin
         irq_stat_nxt[`IRQ_OE_BIT] = 1'b1;
      end
      if (tx_empty_ev) begin
         irq_stat_nxt[`IRQ_TX_EMPTY_BIT] = 1'b1;
      end
   end
   assign irq = |(irq_stat_r & irq_mask_r);

   always @* begin
      rdata_nxt = 32'h00000000;
      if (win_hit) begin
         rdata_nxt[7:0] = fifo_en_r ? rxf_head : rx_hold_r;             // R1 R4 R13
      end else begin
         case (addr)
            `LINE_STAT_OFS: begin
               rdata_nxt[`STAT_READY_BIT]    = ready_r;
               rdata_nxt[`STAT_OVERRUN_BIT]  = oe_r;
               rdata_nxt[`STAT_TX_EMPTY_BIT] = tx_empty_r;
            end
            `FIFO_CTRL_OFS: rdata_nxt[`FIFO_EN_BIT] = fifo_en_r;
            `CTRL_OFS:     rdata_nxt[`CTRL_IR_BIT] = ir_mode_r;
            `IRQ_STAT_OFS: rdata_nxt[2:0] = irq_stat_r;
            `IRQ_MASK_OFS: rdata_nxt[2:0] = irq_mask_r;
            default:       rdata_nxt = 32'h00000000;
         endcase
      end
   end

   always @(posedge sys_clk) begin
      if (!nrst) begin
         rdata <= 32'h00000000;
      end else if (rd) begin
         rdata <= rdata_nxt;
      end else begin
         rdata <= 32'h00000000;
      end
   end
endmodule
`default_nettype wire

// file: verification/shadow_port_chk.sv
// Purpose: Port assertions of the shadow data port
// Assumes: Fixed bit time of BAUD_DIV cycles, 8N1 framing
// Notes:   Bound to the top module after the checker
`timescale 1ns/1ns
`default_nettype none
`include "uart_shadow_map.vh"
module shadow_port_chk (
   input wire logic        sys_clk,
   input wire logic        nrst,
   input wire logic [31:0] addr,
   input wire logic [31:0] wdata,
   input wire logic        wr,
   input wire logic        rd,
   input wire logic [31:0] rdata,
   input wire logic        serial_in,
   input wire logic        serial_out,
   input wire logic        ir_in,
   input wire logic        ir_out_n,
   input wire logic        irq
);
   localparam int BT = `BAUD_DIV;
   logic [13:0] cnt_r;
   logic        wrote_r;
   wire         win = (addr >= `WIN_BASE) && (addr <= `WIN_LAST);
   // Counts cycles from the start edge of each frame transmitted on serial_out
   always @(posedge sys_clk) begin
      if (!nrst) begin
         cnt_r <= 14'h0;
         wrote_r <= 1'b0;
      end else begin
         if (wr && win)
            wrote_r <= 1'b1;
         if (cnt_r == 10 * BT - 1)
            cnt_r <= 14'h0;
         else if (cnt_r != 14'h0 || $fell(serial_out))
            cnt_r <= cnt_r + 14'h1;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   a_upper_zero: assert property (rd && win |=> rdata[31:8] == 24'h0)
      else $error("upper bytes of window read not zero");
   a_rdata_idle: assert property (!rd |=> rdata == 32'h0)
      else $error("read data outside read answer cycle");
   a_reset_lines: assert property (disable iff (1'b0) !nrst |=> serial_out && ir_out_n && !irq)
      else $error("lines not idle after reset");
   a_start_hold: assert property ($fell(serial_out) |-> !serial_out [*8])
      else $error("start bit too short");
   a_start_mid: assert property (cnt_r == BT / 2 |-> !serial_out)
      else $error("start bit not low at mid bit");
   a_stop_high: assert property (cnt_r == 9 * BT + BT / 2 |-> serial_out)
      else $error("stop bit not high");
   a_one_line: assert property (serial_out || ir_out_n)
      else $error("both transmit lines active");
   a_tx_cause: assert property ($fell(serial_out) && cnt_r == 14'h0 |-> wrote_r)
      else $error("frame sent without a write");
   c_win_read: cover property (rd && win);
   c_frame: cover property (cnt_r == 9 * BT);
   c_irq: cover property ($rose(irq));
endmodule
bind uart_shadow_data_port shadow_port_chk shadow_port_chk_inst (
   .sys_clk(sys_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
   .rdata(rdata), .serial_in(serial_in), .serial_out(serial_out), .ir_in(ir_in),
   .ir_out_n(ir_out_n), .irq(irq)
);
`default_nettype wire

// file: verification/line_partner.sv
// Purpose: Remote serial transceiver on the line
// Assumes: 8N1, LSB first, BT cycles per bit
// Notes:   Line idles high between frames
`timescale 1ns/1ns
`default_nettype none
module line_partner #(parameter int BT = 868) (
   input  wire logic       sys_clk,
   input  wire logic       line_in,
   output var  logic       line_out,
   output var  logic       got_stb,
   output var  logic [7:0] got_byte
);
   initial begin
      line_out = 1'b1;
      got_stb = 1'b0;
      got_byte = 8'h00;
   end
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      @(posedge sys_clk);
      for (int i = 0; i < 10; i++) begin
         line_out <= f[i];
         repeat (BT) @(posedge sys_clk);
      end
   endtask
   // Strobe only for a frame with a valid stop bit
   always begin
      @(negedge line_in);
      repeat (BT / 2) @(posedge sys_clk);
      for (int i = 0; i < 8; i++) begin
         repeat (BT) @(posedge sys_clk);
         got_byte[i] <= line_in;
      end
      repeat (BT) @(posedge sys_clk);
      got_stb <= line_in;
      @(posedge sys_clk);
      got_stb <= 1'b0;
   end
endmodule
`default_nettype wire

// file: verification/tb.sv
// Purpose: Self-checking bench of the shadow data port
// Assumes: Partner model on the serial lines
// Notes:   Infrared input held idle
`timescale 1ns/1ns
`default_nettype none
`include "uart_shadow_map.vh"
module tb;
   localparam int BT = `BAUD_DIV;
   logic        sys_clk = 1'b0;
   logic        nrst = 1'b0;
   logic [31:0] addr = 32'h0;
   logic [31:0] wdata = 32'h0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        ir_in = 1'b1;
   wire  [31:0] rdata;
   wire         serial_in;
   wire         serial_out;
   wire         ir_out_n;
   wire         irq;
   wire         got_stb;
   wire  [7:0]  got_byte;
   int          failures = 0;
   int          n_compared = 0;
   int          cyc = 0;
   logic [7:0]  b1, b2, b3;
   logic [7:0]  tx_q[$];
   always #5 sys_clk = ~sys_clk;
   uart_shadow_data_port uart_shadow_data_port_inst (
      .sys_clk(sys_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .serial_in(serial_in), .serial_out(serial_out), .ir_in(ir_in),
      .ir_out_n(ir_out_n), .irq(irq));
   line_partner #(.BT(BT)) line_partner_inst (
      .sys_clk(sys_clk), .line_in(serial_out), .line_out(serial_in),
      .got_stb(got_stb), .got_byte(got_byte));
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask
   task automatic chk_rd(input string nm, input logic [31:0] a, input logic [31:0] exp);
      @(posedge sys_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk);
      rd <= 1'b0;
      #1 check(nm, rdata, exp);
   endtask
   task automatic chk_irq(input logic exp);
      @(posedge sys_clk);
      #1 check("irq", irq, exp);
   endtask
   task automatic wrap_up();
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Sent bytes against the queue of expected characters
   always @(posedge sys_clk) begin
      if (got_stb === 1'b1) begin
         if (tx_q.size() == 0)
            check("tx extra", 32'h1, 32'h0);
         else
            check("tx byte", got_byte, tx_q.pop_front());
      end
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 95000) begin
         failures++;
         wrap_up();
      end
   end
   initial begin
      repeat (8) @(posedge sys_clk);
      nrst <= 1'b1;
      chk_rd("status reset", `LINE_STAT_OFS, 32'h20);
      chk_rd("alias9 reset", `ALIAS9_OFS, 32'h0);
      chk_rd("alias10 reset", `ALIAS10_OFS, 32'h0);
      chk_rd("unmapped", 32'h50001200, 32'h0);
      wr_reg(`IRQ_MASK_OFS, 32'h7);
      b1 = lfsr(8'h46);
      b2 = lfsr(b1);
      b3 = lfsr(b2);
      tx_q.push_back(b1);
      tx_q.push_back(b3);
      wr_reg(`ALIAS9_OFS, {24'hffffff, b1});
      wr_reg(`ALIAS10_OFS, {24'h0, b2});
      chk_rd("status held", `LINE_STAT_OFS, 32'h0);
      wr_reg(`WIN_BASE, {24'h0, b3});
      while (tx_q.size() != 0) @(posedge sys_clk);
      repeat (BT) @(posedge sys_clk);
      chk_irq(1'b1);
      chk_rd("stat tx empty", `IRQ_STAT_OFS, 32'h4);
      wr_reg(`IRQ_STAT_OFS, 32'h7);
      chk_irq(1'b0);
      b1 = lfsr(b3);
      b2 = lfsr(b1);
      line_partner_inst.send(b1);
      line_partner_inst.send(b2);
      repeat (20) @(posedge sys_clk);
      chk_rd("status overrun", `LINE_STAT_OFS, 32'h23);
      chk_rd("rx last", `WIN_BASE + 32'h24, {24'h0, b2});
      chk_rd("stat rx", `IRQ_STAT_OFS, 32'h3);
      wr_reg(`IRQ_MASK_OFS, 32'h0);
      chk_irq(1'b0);
      wr_reg(`IRQ_MASK_OFS, 32'h2);
      chk_irq(1'b1);
      wr_reg(`IRQ_STAT_OFS, 32'h3);
      chk_irq(1'b0);
      wr_reg(`FIFO_CTRL_OFS, 32'h1);
      chk_rd("fifo ctrl", `FIFO_CTRL_OFS, 32'h1);
      b3 = lfsr(b2);
      b1 = lfsr(b3);
      line_partner_inst.send(b3);
      line_partner_inst.send(b1);
      repeat (20) @(posedge sys_clk);
      chk_rd("status fifo", `LINE_STAT_OFS, 32'h21);
      chk_rd("rx head", `WIN_LAST, {24'h0, b3});
      chk_rd("rx next", `ALIAS9_OFS, {24'h0, b1});
      chk_rd("status drained", `LINE_STAT_OFS, 32'h20);
      b2 = lfsr(b1);
      b3 = lfsr(b2);
      tx_q.push_back(b2);
      tx_q.push_back(b3);
      wr_reg(`WIN_BASE + 32'h4, {24'h0, b2});
      wr_reg(`WIN_BASE + 32'h8, {24'h0, b3});
      while (tx_q.size() != 0) @(posedge sys_clk);
      chk_rd("tx drained", `LINE_STAT_OFS, 32'h20);
      wrap_up();
   end
endmodule
`default_nettype wire
